// file: design/tsp_i2c_port.sv
// Target-only two-wire register port with 10-bit auto-incrementing pointer
//
// What this block does
// - Target only; answers address 0101100 only
// - Seven address bits then direction bit, 1 reads
// - Nine clocks per byte: eight bits, acknowledge
// - STOP clears pointer and idles the port
// - Data changes only while clock is low
// - Two write bytes carry 10-bit pointer
// - Next two bytes: value upper then lower
// - Pointer advances after each register written
// - Reads return upper byte, then lower byte
// - Pointer advances per register while master acknowledges
// - Pointer saturates at top; last register repeats
// - Spikes up to 50 ns are ignored
// - Active-low hardware reset pin resets the port logic, but not the line filter
// - Pin low or write 0x000: full reset
// - Write 0x001: calibration and soft reset
`timescale 1ns/1ps
`include "tsp_params.svh"
module tsp_i2c_port #(
    parameter int FILT = `TSP_FILT_CYC,
    parameter int PTR_W = `TSP_PTR_W
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic hardware_reset_pin_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [PTR_W-1:0] rd_addr,
    input wire logic [15:0] rd_data,
    output logic wr_en,
    output logic [PTR_W-1:0] wr_addr,
    output logic [15:0] wr_data,
    output logic dev_reset,
    output logic soft_reset
);
    // Filtered lines and their events
    tsp_line_if line ();

    logic rstp1_ff;                // Reset pin first stage, read only by rstp2_ff
    logic rstp2_ff;                // Reset pin second stage
    tsp_pkg::tsp_state_t state_ff; // Sequencer state
    tsp_pkg::tsp_phase_t phase_ff; // Meaning of the next written byte
    logic [3:0] bit_cnt_ff;        // Bits moved in the current byte
    logic [7:0] shift_ff;          // Receive and transmit shift register
    logic [7:0] hold_hi_ff;        // Upper value byte waiting for its partner
    logic [PTR_W-1:0] ptr_ff;      // Register address pointer
    logic dir_rd_ff;               // Current transfer is a read
    logic rd_lo_ff;                // Next byte sent is the lower half
    logic mack_ff;                 // Master acknowledged the last sent byte
    logic oe_n_ff;                 // Data line release, low drives low
    logic wr_en_ff;                // One-cycle register write strobe
    logic [PTR_W-1:0] wr_addr_ff;  // Register address of that write
    logic [15:0] wr_data_ff;       // Value of that write
    logic dev_reset_ff;            // Whole-device reset request
    logic soft_reset_ff;           // Calibration and soft reset pulse

    // Synchronise the hardware reset pin like any other pin
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rstp1_ff <= 1'b1;
            rstp2_ff <= 1'b1;
        end
        else
        begin
            rstp1_ff <= hardware_reset_pin_n;
            rstp2_ff <= rstp1_ff;
        end
    end

    // Port logic is held in reset while the pin is low
    wire port_rst = rst | ~rstp2_ff;

    // Line filter with its own reset so the pin history stays valid
    tsp_line_filter #(
        .FILT(FILT)
    ) u_filter (
        .clk(clk),
        .rst(rst),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .line(line.src)
    );

    // Saturating pointer step
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        ptr_next = (p == PTR_W'(`TSP_PTR_MAX)) ? p : p + PTR_W'(1);
    endfunction : ptr_next

    // Decodes used by the sequencer
    wire byte_done = bit_cnt_ff == `TSP_BYTE_BITS;
    wire addr_hit = shift_ff[7:1] == `TSP_TGT_ADDR;
    wire is_read = shift_ff[0] == `TSP_DIR_READ;
    wire [7:0] rd_hi_byte = rd_data[15:8];
    wire [7:0] rd_lo_byte = rd_data[7:0];
    wire [PTR_W-1:0] ptr_hi_set = {shift_ff[1:0], ptr_ff[7:0]};
    wire [PTR_W-1:0] ptr_lo_set = {ptr_ff[PTR_W-1:8], shift_ff};
    wire lo_write = state_ff == tsp_pkg::TSP_RX_ACK && line.scl_fall && phase_ff == tsp_pkg::TSP_PH_DAT_LO;

    // Sequencer: bits are sampled on clock rise and driven on clock fall
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            state_ff <= tsp_pkg::TSP_IDLE;
            phase_ff <= tsp_pkg::TSP_PH_PTR_HI;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            hold_hi_ff <= '0;
            ptr_ff <= PTR_W'(`TSP_PTR_RST);
            dir_rd_ff <= 1'b0;
            rd_lo_ff <= 1'b0;
            mack_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end
        else if (line.stop)
        begin
            // Bus released, pointer back to zero, half-written value dropped
            state_ff <= tsp_pkg::TSP_IDLE;
            ptr_ff <= PTR_W'(`TSP_PTR_RST);
            oe_n_ff <= 1'b1;
        end
        else if (line.start)
        begin
            // New address phase; a lone upper byte is discarded
            state_ff <= tsp_pkg::TSP_ADDR;
            bit_cnt_ff <= '0;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            case (state_ff)
                tsp_pkg::TSP_IDLE:
                begin
                    oe_n_ff <= 1'b1;  // Wait for a START
                end
                tsp_pkg::TSP_ADDR, tsp_pkg::TSP_RX:
                begin
                    if (line.scl_rise)
                    begin
                        // MSB first sampling
                        shift_ff <= {shift_ff[6:0], line.sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (line.scl_fall && byte_done)
                    begin
                        bit_cnt_ff <= '0;
                        if (state_ff == tsp_pkg::TSP_RX)
                        begin
                            oe_n_ff <= 1'b0;  // Acknowledge every byte
                            state_ff <= tsp_pkg::TSP_RX_ACK;
                        end
                        else if (addr_hit)
                        begin
                            oe_n_ff <= 1'b0;  // Acknowledge own address
                            dir_rd_ff <= is_read;
                            state_ff <= tsp_pkg::TSP_ADDR_ACK;
                        end
                        else
                        begin
                            state_ff <= tsp_pkg::TSP_IDLE;  // Other target, stay silent
                        end
                    end
                end
                tsp_pkg::TSP_ADDR_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        if (dir_rd_ff)
                        begin
                            // Upper byte of the pointed register goes out first
                            shift_ff <= rd_hi_byte;
                            oe_n_ff <= rd_hi_byte[7];
                            bit_cnt_ff <= 4'h1;
                            rd_lo_ff <= 1'b1;
                            state_ff <= tsp_pkg::TSP_TX;
                        end
                        else
                        begin
                            oe_n_ff <= 1'b1;
                            phase_ff <= tsp_pkg::TSP_PH_PTR_HI;
                            state_ff <= tsp_pkg::TSP_RX;
                        end
                    end
                end
                tsp_pkg::TSP_RX_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        oe_n_ff <= 1'b1;
                        state_ff <= tsp_pkg::TSP_RX;
                        case (phase_ff)
                            tsp_pkg::TSP_PH_PTR_HI:
                            begin
                                ptr_ff <= ptr_hi_set;  // Bits 7:2 ignored
                                phase_ff <= tsp_pkg::TSP_PH_PTR_LO;
                            end
                            tsp_pkg::TSP_PH_PTR_LO:
                            begin
                                ptr_ff <= ptr_lo_set;
                                phase_ff <= tsp_pkg::TSP_PH_DAT_HI;
                            end
                            tsp_pkg::TSP_PH_DAT_HI:
                            begin
                                hold_hi_ff <= shift_ff;  // Kept until its partner arrives
                                phase_ff <= tsp_pkg::TSP_PH_DAT_LO;
                            end
                            default:
                            begin
                                ptr_ff <= ptr_next(ptr_ff);  // Next pair to next register
                                phase_ff <= tsp_pkg::TSP_PH_DAT_HI;
                            end
                        endcase
                    end
                end
                tsp_pkg::TSP_TX:
                begin
                    if (line.scl_fall)
                    begin
                        if (byte_done)
                        begin
                            oe_n_ff <= 1'b1;  // Let the master acknowledge
                            state_ff <= tsp_pkg::TSP_TX_ACK;
                        end
                        else
                        begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            oe_n_ff <= shift_ff[6];  // Change data only with clock low
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                tsp_pkg::TSP_TX_ACK:
                begin
                    if (line.scl_rise)
                    begin
                        mack_ff <= ~line.sda;
                    end
                    else if (line.scl_fall)
                    begin
                        if (!mack_ff)
                        begin
                            state_ff <= tsp_pkg::TSP_IDLE;  // No-acknowledge ends the read
                        end
                        else if (rd_lo_ff)
                        begin
                            // Lower half sent next; the register counts as read now, before that half goes out
                            shift_ff <= rd_lo_byte;
                            oe_n_ff <= rd_lo_byte[7];
                            bit_cnt_ff <= 4'h1;
                            rd_lo_ff <= 1'b0;
                            ptr_ff <= ptr_next(ptr_ff);  // Saturates, repeating the top register
                            state_ff <= tsp_pkg::TSP_TX;
                        end
                        else
                        begin
                            shift_ff <= rd_hi_byte;
                            oe_n_ff <= rd_hi_byte[7];
                            bit_cnt_ff <= 4'h1;
                            rd_lo_ff <= 1'b1;
                            state_ff <= tsp_pkg::TSP_TX;
                        end
                    end
                end
                default:
                begin
                    state_ff <= tsp_pkg::TSP_IDLE;
                end
            endcase
        end
    end

    // Register write strobe, only once both value bytes were acknowledged
    always_ff @(posedge clk)
    begin
        if (port_rst)
        begin
            wr_en_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
        end
        else
        begin
            wr_en_ff <= lo_write;
            if (lo_write)
            begin
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= {hold_hi_ff, shift_ff};  // Upper byte then lower
            end
        end
    end

    // Device-wide reset requests from the pin and the two command registers
    wire hw_cmd = lo_write && ptr_ff == PTR_W'(`TSP_REG_HWRST);
    wire sw_cmd = lo_write && ptr_ff == PTR_W'(`TSP_REG_SWRST);
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dev_reset_ff <= 1'b1;
            soft_reset_ff <= 1'b0;
        end
        else
        begin
            dev_reset_ff <= ~rstp2_ff | hw_cmd;
            soft_reset_ff <= sw_cmd & rstp2_ff;
        end
    end

    // Open-drain data pin: output always low, only the enable moves
    always_ff @(posedge clk)
    begin
        sda_out <= 1'b0;
    end

    // Outputs straight from flip-flops
    assign sda_oe_n = oe_n_ff;
    assign rd_addr = ptr_ff;
    assign wr_en = wr_en_ff;
    assign wr_addr = wr_addr_ff;
    assign wr_data = wr_data_ff;
    assign dev_reset = dev_reset_ff;
    assign soft_reset = soft_reset_ff;
endmodule : tsp_i2c_port

// file: design/tsp_line_filter.sv
// Synchroniser, spike filter and edge finder for the two bus lines
`timescale 1ns/1ps
`include "tsp_params.svh"
module tsp_line_filter #(
    parameter int FILT = `TSP_FILT_CYC
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    tsp_line_if.src line
);
    localparam int CW = $clog2(FILT + 1);

    logic [1:0] s1_ff;      // First synchroniser stage, read only by s2_ff
    logic [1:0] s2_ff;      // Second synchroniser stage
    logic [1:0] stable_ff;  // Accepted line levels, bit 1 clock, bit 0 data
    logic [1:0] prev_ff;    // Accepted levels one cycle earlier

    // Two flip-flops before any logic sees the pins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_ff <= 2'h3;
            s2_ff <= 2'h3;
        end
        else
        begin
            s1_ff <= {scl_pin, sda_pin};
            s2_ff <= s1_ff;
        end
    end

    // A new level is taken only after it holds longer than a spike
    for (genvar g = 0; g < 2; g++)
    begin : g_filt
        logic [CW-1:0] cnt_ff;  // Cycles the new level has held
        wire differs = s2_ff[g] != stable_ff[g];
        always_ff @(posedge clk)
        begin
            if (rst || !differs)
            begin
                cnt_ff <= '0;  // Short pulses never reach the limit
            end
            else if (cnt_ff == CW'(FILT - 1))
            begin
                cnt_ff <= '0;
            end
            else
            begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                stable_ff[g] <= 1'b1;
            end
            else if (differs && cnt_ff == CW'(FILT - 1))
            begin
                stable_ff[g] <= s2_ff[g];
            end
        end
    end

    // Edge and condition decode on the accepted levels
    wire scl_hi_both = stable_ff[1] & prev_ff[1];
    wire nxt_start = scl_hi_both & prev_ff[0] & ~stable_ff[0];  // Data falls, clock high
    wire nxt_stop = scl_hi_both & ~prev_ff[0] & stable_ff[0];   // Data rises, clock high

    // Register levels and one-cycle events for the sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_ff <= 2'h3;
            line.scl <= 1'b1;
            line.sda <= 1'b1;
            line.scl_rise <= 1'b0;
            line.scl_fall <= 1'b0;
            line.start <= 1'b0;
            line.stop <= 1'b0;
        end
        else
        begin
            prev_ff <= stable_ff;
            line.scl <= stable_ff[1];
            line.sda <= stable_ff[0];
            line.scl_rise <= stable_ff[1] & ~prev_ff[1];
            line.scl_fall <= ~stable_ff[1] & prev_ff[1];
            line.start <= nxt_start;
            line.stop <= nxt_stop;
        end
    end
endmodule : tsp_line_filter

// file: pkg/tsp_line_if.sv
// Filtered bus line levels and events between filter and sequencer
`timescale 1ns/1ps
interface tsp_line_if;
    logic scl;       // Filtered clock level
    logic sda;       // Filtered data level
    logic scl_rise;  // One-cycle pulse on clock rising edge
    logic scl_fall;  // One-cycle pulse on clock falling edge
    logic start;     // One-cycle pulse on START or repeated START
    logic stop;      // One-cycle pulse on STOP

    modport src (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
    modport dst (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface : tsp_line_if

// file: pkg/tsp_params.svh
// Constants for the touch sensor serial register port
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH

// Fixed 7-bit target address 0101100
`define TSP_TGT_ADDR 7'h2C
// Direction bit values
`define TSP_DIR_READ 1'b1
// Bits per byte on the wire
`define TSP_BYTE_BITS 4'h8
// Register address pointer
`define TSP_PTR_W 10
`define TSP_PTR_RST 10'h000
`define TSP_PTR_MAX 10'h3FF
// Registers with side effects on write
`define TSP_REG_HWRST 10'h000
`define TSP_REG_SWRST 10'h001
// Clock rate and spike suppression time
`define TSP_CLK_MHZ 125
`define TSP_SPIKE_NS 50
// Cycles a spike may last, rounded up, plus one so a full spike is rejected
`define TSP_SPIKE_CYC ((`TSP_SPIKE_NS * `TSP_CLK_MHZ + 999) / 1000)
`define TSP_FILT_CYC (`TSP_SPIKE_CYC + 1)

`endif

// file: pkg/tsp_pkg.sv
// Types shared by the serial register port modules
package tsp_pkg;

    // Port sequencer states
    typedef enum logic [2:0] {
        TSP_IDLE,
        TSP_ADDR,
        TSP_ADDR_ACK,
        TSP_RX,
        TSP_RX_ACK,
        TSP_TX,
        TSP_TX_ACK
    } tsp_state_t;

    // Meaning of the next received byte in a write
    typedef enum logic [1:0] {
        TSP_PH_PTR_HI,
        TSP_PH_PTR_LO,
        TSP_PH_DAT_HI,
        TSP_PH_DAT_LO
    } tsp_phase_t;

endpackage : tsp_pkg

// file: tb/tb_top.sv
// Testbench for the two-wire register port
`timescale 1ns/1ps
`include "tsp_params.svh"
module tb_top;
    logic clk = 1'b0; // System clock
    logic rst = 1'b1; // Synchronous reset
    logic hardware_reset_pin_n = 1'b1; // Reset pin, idle high
    logic scl_in; // Bus pins from the master model
    logic sda_in;
    logic sda_out; // Port outputs
    logic sda_oe_n;
    logic [9:0] rd_addr;
    logic [15:0] rd_data;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [15:0] wr_data;
    logic dev_reset;
    logic soft_reset;
    logic dev_d = 1'b0; // Last reset output level
    logic [15:0] mem [1024]; // Registers behind the port
    logic [25:0] wq [$]; // Writes seen: pointer, value
    int n_fail = 0;
    int tests_run = 0;
    int n_dev = 0; // Full reset pulses
    int n_soft = 0; // Soft reset pulses
    // Clock
    initial
    begin
        forever #4 clk = ~clk;
    end
    tsp_i2c_port #(.FILT(2), .PTR_W(10)) dut (.clk(clk), .rst(rst), .hardware_reset_pin_n(hardware_reset_pin_n),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .dev_reset(dev_reset),
        .soft_reset(soft_reset));
    tsp_master mst (.clk(clk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl_pin(scl_in), .sda_pin(sda_in));
    // Initial register contents
    function automatic logic [15:0] pat(input int i);
        return 16'hC300 ^ 16'(i);
    endfunction : pat
    initial
    begin
        foreach (mem[i])
            mem[i] = pat(i);
    end
    // Register file answers the pointer at once
    assign rd_data = $isunknown(rd_addr) ? 16'h0000 : mem[rd_addr];
    // Record writes and reset pulses
    always @(posedge clk)
    begin
        dev_d <= dev_reset;
        if (wr_en === 1'b1)
        begin
            mem[wr_addr] <= wr_data;
            wq.push_back({wr_addr, wr_data});
        end
        if (dev_reset === 1'b1 && dev_d === 1'b0)
            n_dev++;
        if (soft_reset === 1'b1)
            n_soft++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One written byte, acknowledged by the port
    task automatic send(input logic [7:0] b);
        logic [7:0] q;
        logic a;
        mst.byte_io(b, 1'b1, q, a);
        chk("ack", 16'h0000, {15'h0000, a});
    endtask : send
    // Address the port for writing and load the pointer
    task automatic put_ptr(input logic [9:0] p);
        mst.start();
        send({`TSP_TGT_ADDR, 1'b0});
        send({6'h3F, p[9:8]});
        send(p[7:0]);
    endtask : put_ptr
    // Two read bytes against an expected word
    task automatic rdw(input logic last, input logic [15:0] e);
        logic [7:0] hi;
        logic [7:0] lo;
        logic a;
        mst.byte_io(8'hFF, 1'b0, hi, a);
        mst.byte_io(8'hFF, last, lo, a);
        chk("read word", e, {hi, lo});
    endtask : rdw
    task automatic open_rd;
        mst.start();
        send({`TSP_TGT_ADDR, 1'b1});
    endtask : open_rd
    task automatic fin;
        mst.stop();
        repeat (16) @(posedge clk);
    endtask : fin
    task automatic t_write;
        wq.delete();
        put_ptr(10'h123);
        send(8'hAB);
        send(8'hCD);
        mst.gl_en = 1'b1;
        send(8'h12);
        send(8'h34);
        fin();
        chk("write count", 16'h0002, 16'(wq.size()));
        chk("addr0", 16'h0123, 16'(wq[0][25:16]));
        chk("data0", 16'hABCD, wq[0][15:0]);
        chk("addr1", 16'h0124, 16'(wq[1][25:16]));
        chk("data1", 16'h1234, wq[1][15:0]);
        chk("pointer", 16'h0000, 16'(rd_addr));
        $display("t_write done");
    endtask : t_write
    task automatic t_read;
        put_ptr(10'h123);
        open_rd();
        rdw(1'b0, 16'hABCD);
        rdw(1'b1, 16'h1234);
        fin();
        $display("t_read done");
    endtask : t_read
    task automatic t_sat;
        put_ptr(10'h3FE);
        open_rd();
        rdw(1'b0, pat(10'h3FE));
        rdw(1'b0, pat(10'h3FF));
        rdw(1'b1, pat(10'h3FF));
        fin();
        $display("t_sat done");
    endtask : t_sat
    task automatic t_addr;
        logic [7:0] bad [3] = '{8'h5A, 8'h18, 8'hD9};
        logic [7:0] q;
        logic a;
        foreach (bad[i])
        begin
            mst.start();
            mst.byte_io(bad[i], 1'b1, q, a);
            chk("foreign nack", 16'h0001, {15'h0000, a});
            fin();
        end
        $display("t_addr done");
    endtask : t_addr
    task automatic t_lone;
        wq.delete();
        put_ptr(10'h050);
        send(8'hEE);
        fin();
        chk("lone byte", 16'h0000, 16'(wq.size()));
        open_rd();
        rdw(1'b1, pat(0));
        fin();
        $display("t_lone done");
    endtask : t_lone
    task automatic t_pin;
        put_ptr(10'h0AA);
        repeat (12) @(posedge clk);
        chk("ptr load", 16'h00AA, 16'(rd_addr));
        hardware_reset_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("pin reset", 16'h0001, {15'h0000, dev_reset});
        chk("pin ptr", 16'h0000, 16'(rd_addr));
        hardware_reset_pin_n <= 1'b1;
        fin();
        chk("pin done", 16'h0000, {15'h0000, dev_reset});
        $display("t_pin done");
    endtask : t_pin
    task automatic t_cmd;
        n_dev = 0;
        n_soft = 0;
        put_ptr(10'h000);
        repeat (4) send(8'h00);
        fin();
        chk("full reset", 16'h0001, 16'(n_dev));
        chk("soft reset", 16'h0001, 16'(n_soft));
        $display("t_cmd done");
    endtask : t_cmd
    task automatic end_sim;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (24) @(posedge clk);
        t_write();
        t_read();
        t_sat();
        t_addr();
        t_lone();
        t_pin();
        t_cmd();
        end_sim();
    end
    // Watchdog cuts a hang short
    initial
    begin
        #500000;
        n_fail++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tb_top

// file: tb/tsp_chk.sv
// Port checker for the two-wire register port
`timescale 1ns/1ps
module tsp_chk #(
    parameter int FILT = 8,
    parameter int PTR_W = 10
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic hardware_reset_pin_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [PTR_W-1:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic wr_en,
    input wire logic [PTR_W-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic dev_reset,
    input wire logic soft_reset
);
    // Pointer expected after a write, held at the top
    wire [PTR_W-1:0] ptr_inc = (&wr_addr) ? wr_addr : wr_addr + 1'b1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Data line only moves while the clock is low
    property p_sda_move;
        $changed(sda_oe_n) |-> !scl_in;
    endproperty
    a_sda_move: assert property (p_sda_move) else $error("data moved, clock high");
    // A driven data line is always pulled low
    property p_pull_low;
        !sda_oe_n |-> !sda_out;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("driven line not low");
    // A bus stop clears the pointer
    property p_stop_clr;
        scl_in && $past(scl_in) && $rose(sda_in) && !$past(sda_in, 2) |-> ##[1:20] rd_addr == '0;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("pointer kept after stop");
    // Pointer steps on after each register written
    property p_wr_step;
        wr_en |-> ##[0:2] rd_addr == ptr_inc;
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("pointer not advanced");
    // Reset pin low raises the device reset
    property p_pin_rst;
        !hardware_reset_pin_n [*6] |-> dev_reset;
    endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("no reset from pin");
    // Reset pin low keeps the port quiet
    property p_pin_quiet;
        !hardware_reset_pin_n [*6] |-> sda_oe_n && !wr_en && rd_addr == '0;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("port active in reset");
    // Write to register zero gives a full reset
    property p_hw_cmd;
        wr_en && wr_addr == '0 |-> ##[0:2] dev_reset;
    endproperty
    a_hw_cmd: assert property (p_hw_cmd) else $error("no reset on command");
    // Write to register one gives one soft reset pulse
    property p_sw_cmd;
        wr_en && wr_addr == PTR_W'(1) |-> ##[0:2] soft_reset ##1 !soft_reset;
    endproperty
    a_sw_cmd: assert property (p_sw_cmd) else $error("bad soft reset");
endmodule : tsp_chk

bind tsp_i2c_port tsp_chk #(.FILT(FILT), .PTR_W(PTR_W)) u_chk (.clk(clk), .rst(rst),
    .hardware_reset_pin_n(hardware_reset_pin_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .dev_reset(dev_reset), .soft_reset(soft_reset));

// file: tb/tsp_master.sv
// Bus master model that drives the two-wire port
`timescale 1ns/1ps
module tsp_master (
    input wire logic clk,
    input wire logic sda_oe_n,
    input wire logic sda_out,
    output logic scl_pin = 1'b1,
    output logic sda_pin = 1'b1
);
    localparam realtime Q = 31.25; // Quarter of the 125 ns link period
    logic scl_q = 1'b1; // Wanted clock level, still outside frames
    logic sda_q = 1'b1; // Data level from this side
    logic gl = 1'b0; // Inverts the data pin for one cycle
    logic gl_en = 1'b0; // Arms one spike in the next byte
    // Pins move at the clock edge; a released line floats up
    always @(posedge clk)
    begin
        scl_pin <= scl_q;
        sda_pin <= (sda_oe_n === 1'b0) ? (sda_out & sda_q) : (sda_q ^ gl);
    end
    // Start; clock rises only after the port has let go of its acknowledge
    task automatic start;
        sda_q = 1'b1;
        #(3*Q) scl_q = 1'b1;
        #(2*Q) sda_q = 1'b0;
        #(2*Q) scl_q = 1'b0;
    endtask : start
    // Stop: data rises while the clock is high
    task automatic stop;
        #(Q) sda_q = 1'b0;
        #(2*Q) scl_q = 1'b1;
        #(2*Q) sda_q = 1'b1;
        #(4*Q);
    endtask : stop
    // Eight bits from the top then the acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic [8:0] sh;
        sh = {d, mack};
        for (int i = 8; i >= 0; i--)
        begin
            #(Q) sda_q = sh[i];
            #(2*Q) scl_q = 1'b1;
            #(Q/2);
            if (i > 0)
                q[i-1] = sda_pin;
            else
                ack = sda_pin;
            // Short spike on a high bit while the clock is high
            if (gl_en && sh[i] && i > 0)
            begin
                gl = 1'b1;
                @(posedge clk);
                #1 gl = 1'b0;
                gl_en = 1'b0;
            end
            #(Q/2) scl_q = 1'b0;
        end
    endtask : byte_io
endmodule : tsp_master
